// file: rtl/sdram_cmd_fsm.sv
// command decode and state transitions of a two-bank synchronous dram
// How it works
// - gate falling in row active, read, read with auto close, write or write recovery: enter clock freeze, other inputs ignored
// - in clock freeze a rising gate resumes the frozen state
// - idle: deselect, idle cycle, halt do nothing, or low power if gate drops without renew
// - read burst runs out on idle cycles, then back to row active
// - halt during read cuts the burst, back to row active
// - read command during read restarts the read at the new column
// - write command during read starts a write; controller avoids data contention
// - bank close during read stops the burst and precharges
// - write burst runs out on idle cycles, then write recovery
// - halt during write stops it, back to row active
// - read command during write starts a read at the new column
// - write command during write restarts writing at the new column
// - bank close during write stops the burst and precharges
// - read with auto close runs out, then precharges by itself
// - renew with gate falling from idle self-refreshes until gate rises
// - low power starts on gate falling and holds while it stays low
`timescale 1ns/100ps
`include "sdram_cmd_cfg.svh"
module sdram_cmd_fsm
    import sdram_cmd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // command pins from the controller
    input cmd_pins_t pins,
    input wire logic [`DATA_W-1:0] wr_data,
    // read data stream
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [`DATA_W-1:0] rd_data,
    // status
    output dev_state_t dev_state,
    output logic [`NUM_BANKS-1:0] bank_open,
    output logic illegal_cmd
);

    dec_t dec;
    dev_state_t state_r;
    dev_state_t saved_state_r;
    logic cke_prev_r;
    logic [`NUM_BANKS-1:0] bank_open_r;
    logic bank_r;
    logic ap_r;
    logic [`COL_W-1:0] col_r;
    logic [3:0] cnt_r;
    logic [`TIMER_W-1:0] timer_r;
    logic [`TIMER_W-1:0] timer_limit;
    logic illegal_cmd_r;
    logic illegal_nxt;
    logic rd_valid_r;
    logic [`DATA_W-1:0] rd_data_r;
    logic [`DATA_W-1:0] mem [`NUM_BANKS][2**`COL_W];
    logic cke_fall;
    logic cke_rise;
    logic cmd_ok;
    logic active_st;
    logic in_read;
    logic col_st;
    logic burst_st;
    logic interrupt;
    logic accept_col;
    logic rd_beat;
    logic wr_beat;
    logic burst_last;
    logic timer_done;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`DATA_W-1:0] fifo_out_data;

    sdram_cmd_decode u_decode (
        .pins(pins),
        .dec(dec)
    );

    assign cke_fall = cke_prev_r && !pins.clock_gate_input;
    assign cke_rise = !cke_prev_r && pins.clock_gate_input;
    assign cmd_ok = cke_prev_r && pins.clock_gate_input;
    assign active_st = (state_r == ST_ROW_ACTIVE) || (state_r == ST_READ) || (state_r == ST_READ_AP)
                    || (state_r == ST_WRITE) || (state_r == ST_WRITE_REC);
    assign in_read = (state_r == ST_READ) || (state_r == ST_READ_AP);
    assign burst_st = (state_r == ST_READ) || (state_r == ST_WRITE);
    assign col_st = burst_st || (state_r == ST_ROW_ACTIVE) || (state_r == ST_WRITE_REC);
    assign interrupt = cmd_ok && burst_st && ((dec.cmd == CMD_BURST_HALT) || (dec.cmd == CMD_FETCH)
                    || (dec.cmd == CMD_STORE) || (dec.cmd == CMD_BANK_CLOSE));
    assign accept_col = cmd_ok && col_st && ((dec.cmd == CMD_FETCH) || (dec.cmd == CMD_STORE));
    // a full fifo stalls the read burst rather than dropping a beat
    assign rd_beat = in_read && pins.clock_gate_input && fifo_in_ready && !interrupt;
    assign wr_beat = (state_r == ST_WRITE) && pins.clock_gate_input && !interrupt;
    assign burst_last = (cnt_r == `BURST_LAST);
    assign timer_done = (timer_r == timer_limit);

    always_comb begin
        unique case (state_r)
            ST_PRECHARGE: timer_limit = `TIMER_W'(`TRP_CYC - 1);
            ST_REFRESH: timer_limit = `TIMER_W'(`TRC_CYC - 1);
            default: timer_limit = `TIMER_W'(`TDPL_CYC - 1);
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cke_prev_r <= 1'b1;
        end else begin
            cke_prev_r <= pins.clock_gate_input;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            saved_state_r <= ST_IDLE;
        end else if (active_st && cke_fall) begin
            saved_state_r <= state_r;
            state_r <= ST_FREEZE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (cke_fall) begin
                        state_r <= (dec.cmd == CMD_RENEW) ? ST_SELF_REFRESH : ST_POWER_DOWN;
                    end else if (cmd_ok && dec.cmd == CMD_ROW_OPEN) begin
                        state_r <= ST_ROW_ACTIVE;
                    end else if (cmd_ok && dec.cmd == CMD_RENEW) begin
                        state_r <= ST_REFRESH;
                    end
                end
                ST_ROW_ACTIVE, ST_READ, ST_WRITE, ST_WRITE_REC: begin
                    if (accept_col && dec.cmd == CMD_FETCH) begin
                        state_r <= dec.autoclose ? ST_READ_AP : ST_READ;
                    end else if (accept_col) begin
                        state_r <= ST_WRITE;
                    end else if (cmd_ok && dec.cmd == CMD_BANK_CLOSE && state_r != ST_WRITE_REC) begin
                        state_r <= ST_PRECHARGE;
                    end else if (interrupt) begin
                        state_r <= ST_ROW_ACTIVE;
                    end else if (rd_beat && burst_last) begin
                        state_r <= ST_ROW_ACTIVE;
                    end else if (wr_beat && burst_last) begin
                        state_r <= ST_WRITE_REC;
                    end else if (state_r == ST_WRITE_REC && timer_done) begin
                        state_r <= ap_r ? ST_PRECHARGE : ST_ROW_ACTIVE;
                    end
                end
                ST_READ_AP: begin
                    if (rd_beat && burst_last) begin
                        state_r <= ST_PRECHARGE;
                    end
                end
                ST_PRECHARGE: begin
                    if (timer_done) begin
                        state_r <= (bank_open_r != '0) ? ST_ROW_ACTIVE : ST_IDLE;
                    end
                end
                ST_REFRESH: begin
                    if (timer_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_SELF_REFRESH: begin
                    // recovery after self-refresh reuses the refresh timer
                    if (cke_rise) begin
                        state_r <= ST_REFRESH;
                    end
                end
                ST_POWER_DOWN: begin
                    if (cke_rise) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_FREEZE: begin
                    if (cke_rise) begin
                        state_r <= saved_state_r;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_r <= '0;
        end else if ((state_r == ST_PRECHARGE || state_r == ST_REFRESH || state_r == ST_WRITE_REC) && !timer_done) begin
            timer_r <= timer_r + `TIMER_W'(1);
        end else begin
            timer_r <= '0;
        end
    end

    // column pointer and beat count of the running burst
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            col_r <= '0;
            cnt_r <= '0;
            bank_r <= 1'b0;
            ap_r <= 1'b0;
        end else if (accept_col && !(active_st && cke_fall)) begin
            col_r <= dec.col;
            cnt_r <= `BURST_LEN;
            bank_r <= dec.bank;
            ap_r <= dec.autoclose;
        end else if (rd_beat || wr_beat) begin
            col_r <= col_r + `COL_W'(1);
            cnt_r <= cnt_r - 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_open_r <= '0;
        end else if (state_r == ST_IDLE && cmd_ok && dec.cmd == CMD_ROW_OPEN) begin
            bank_open_r[dec.bank] <= 1'b1;
        end else if (cmd_ok && dec.cmd == CMD_BANK_CLOSE && (state_r == ST_ROW_ACTIVE || burst_st)) begin
            if (dec.autoclose) begin
                bank_open_r <= '0;
            end else begin
                bank_open_r[dec.bank] <= 1'b0;
            end
        end else if ((state_r == ST_READ_AP && rd_beat && burst_last)
                  || (state_r == ST_WRITE_REC && timer_done && ap_r && !accept_col && pins.clock_gate_input)) begin
            bank_open_r[bank_r] <= 1'b0;
        end
    end

    // row address is not modelled: each bank keeps one page of columns
    always_ff @(posedge sys_clk) begin
        if (wr_beat) begin
            mem[bank_r][col_r] <= wr_data;
        end
    end

    always_comb begin
        illegal_nxt = 1'b0;
        if (cmd_ok) begin
            unique case (state_r)
                ST_IDLE: illegal_nxt = (dec.cmd == CMD_FETCH) || (dec.cmd == CMD_STORE);
                ST_ROW_ACTIVE, ST_READ, ST_WRITE: illegal_nxt = (dec.cmd == CMD_ROW_OPEN)
                    || (dec.cmd == CMD_RENEW) || (dec.cmd == CMD_CONFIG_LOAD);
                ST_READ_AP: illegal_nxt = (dec.cmd != CMD_DESELECT) && (dec.cmd != CMD_IDLE_CYCLE);
                ST_WRITE_REC: illegal_nxt = (dec.cmd == CMD_ROW_OPEN) || (dec.cmd == CMD_BANK_CLOSE)
                    || (dec.cmd == CMD_RENEW) || (dec.cmd == CMD_CONFIG_LOAD);
                ST_PRECHARGE, ST_REFRESH: illegal_nxt = (dec.cmd != CMD_DESELECT) && (dec.cmd != CMD_IDLE_CYCLE)
                    && (dec.cmd != CMD_BURST_HALT) && (dec.cmd != CMD_BANK_CLOSE || state_r == ST_REFRESH);
                default: illegal_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            illegal_cmd_r <= 1'b0;
        end else begin
            illegal_cmd_r <= illegal_nxt;
        end
    end

    sdram_rd_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(rd_beat),
        .in_ready(fifo_in_ready),
        .in_data(mem[bank_r][col_r]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // output stage keeps every top output on a flip-flop
    assign fifo_out_ready = !rd_valid_r || rd_ready;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
        end else if (fifo_out_ready) begin
            rd_valid_r <= fifo_out_valid;
            if (fifo_out_valid) begin
                rd_data_r <= fifo_out_data;
            end
        end
    end

    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
    assign dev_state = state_r;
    assign bank_open = bank_open_r;
    assign illegal_cmd = illegal_cmd_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_freeze_entry;
        active_st && cke_prev_r && !pins.clock_gate_input |=> state_r == ST_FREEZE;
    endproperty
    a_freeze_entry: assert property (p_freeze_entry) else $error("no clock freeze on gate fall");

    property p_freeze_exit;
        state_r == ST_FREEZE && cke_rise |=> state_r == $past(saved_state_r) && state_r != ST_FREEZE;
    endproperty
    a_freeze_exit: assert property (p_freeze_exit) else $error("clock freeze exit lost state");

    property p_idle_low_power;
        state_r == ST_IDLE && cke_fall && dec.cmd != CMD_RENEW |=> state_r == ST_POWER_DOWN;
    endproperty
    a_idle_low_power: assert property (p_idle_low_power) else $error("idle gate fall missed low power");

    property p_read_done;
        state_r == ST_READ && rd_beat && burst_last |=> state_r == ST_ROW_ACTIVE;
    endproperty
    a_read_done: assert property (p_read_done) else $error("read burst end not row active");

    property p_halt;
        burst_st && cmd_ok && dec.cmd == CMD_BURST_HALT && !pins.cs_n |=> state_r == ST_ROW_ACTIVE;
    endproperty
    a_halt: assert property (p_halt) else $error("burst halt ignored");

    property p_new_read;
        burst_st && cmd_ok && dec.cmd == CMD_FETCH |=> in_read && col_r == $past(dec.col) && cnt_r == `BURST_LEN;
    endproperty
    a_new_read: assert property (p_new_read) else $error("read restart wrong");

    property p_new_write;
        burst_st && cmd_ok && dec.cmd == CMD_STORE |=> state_r == ST_WRITE && col_r == $past(dec.col);
    endproperty
    a_new_write: assert property (p_new_write) else $error("write start wrong");

    property p_close;
        burst_st && cmd_ok && dec.cmd == CMD_BANK_CLOSE |=> state_r == ST_PRECHARGE ##1 state_r != ST_READ;
    endproperty
    a_close: assert property (p_close) else $error("bank close did not precharge");

    property p_write_done;
        state_r == ST_WRITE && wr_beat && burst_last |=> state_r == ST_WRITE_REC;
    endproperty
    a_write_done: assert property (p_write_done) else $error("write burst end not recovery");

    property p_read_ap_done;
        state_r == ST_READ_AP && rd_beat && burst_last |=> state_r == ST_PRECHARGE ##[1:8] state_r != ST_PRECHARGE;
    endproperty
    a_read_ap_done: assert property (p_read_ap_done) else $error("auto close did not precharge");

    property p_read_ap_illegal;
        state_r == ST_READ_AP && cmd_ok && dec.cmd == CMD_STORE |=> illegal_cmd_r && $stable(state_r);
    endproperty
    a_read_ap_illegal: assert property (p_read_ap_illegal) else $error("illegal command not flagged");

    property p_row_open;
        state_r == ST_IDLE && cmd_ok && dec.cmd == CMD_ROW_OPEN |=> state_r == ST_ROW_ACTIVE && bank_open_r != '0;
    endproperty
    a_row_open: assert property (p_row_open) else $error("row open did not activate");

    property p_self_refresh;
        state_r == ST_IDLE && cke_fall && dec.cmd == CMD_RENEW |=> state_r == ST_SELF_REFRESH;
    endproperty
    a_self_refresh: assert property (p_self_refresh) else $error("self refresh not entered");

    property p_low_power_hold;
        state_r == ST_POWER_DOWN && !pins.clock_gate_input |=> state_r == ST_POWER_DOWN;
    endproperty
    a_low_power_hold: assert property (p_low_power_hold) else $error("low power left early");

    c_read_burst: cover property (state_r == ST_READ && rd_beat && burst_last);
    c_freeze: cover property (state_r == ST_FREEZE ##1 cke_rise);
    c_self_refresh: cover property (state_r == ST_SELF_REFRESH ##1 state_r == ST_REFRESH);
    c_write_rec: cover property (state_r == ST_WRITE_REC ##1 state_r == ST_ROW_ACTIVE);

endmodule

// file: rtl/sdram_cmd_cfg.svh
// constants for the sdram command state machine
`ifndef SDRAM_CMD_CFG_SVH
`define SDRAM_CMD_CFG_SVH

`define DATA_W 16
`define ADDR_W 12
`define COL_W 8
`define NUM_BANKS 2
`define AUTOCLOSE_BIT 10
`define BANK_BIT 11
`define BURST_LEN 4'h4
`define BURST_LAST 4'h1
`define FIFO_DEPTH 4
`define TIMER_W 4

// command codes on {row strobe, column strobe, write strobe}, active low
`define CODE_IDLE_CYCLE 3'h7
`define CODE_BURST_HALT 3'h6
`define CODE_FETCH 3'h5
`define CODE_STORE 3'h4
`define CODE_ROW_OPEN 3'h3
`define CODE_BANK_CLOSE 3'h2
`define CODE_RENEW 3'h1
`define CODE_CONFIG_LOAD 3'h0

// timing in ns, least times rounded up to whole cycles of sys_clk
`define CLK_NS 40
`define TRP_NS 20
`define TRC_NS 70
`define TDPL_NS 10
`define TRP_CYC (((`TRP_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define TRC_CYC (((`TRC_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define TDPL_CYC (((`TDPL_NS) + (`CLK_NS) - 1) / (`CLK_NS))

// renew demand kept by the controller
`define RENEW_COUNT 4096
`define RENEW_PERIOD_MS 128

`endif

// file: rtl/sdram_cmd_pkg.sv
// types shared by the sdram command state machine
`include "sdram_cmd_cfg.svh"
package sdram_cmd_pkg;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic clock_gate_input;
        logic [`ADDR_W-1:0] addr;
    } cmd_pins_t;

    typedef enum logic [3:0] {
        CMD_DESELECT,
        CMD_IDLE_CYCLE,
        CMD_BURST_HALT,
        CMD_FETCH,
        CMD_STORE,
        CMD_ROW_OPEN,
        CMD_BANK_CLOSE,
        CMD_RENEW,
        CMD_CONFIG_LOAD
    } cmd_t;

    typedef struct packed {
        cmd_t cmd;
        logic autoclose;
        logic bank;
        logic [`COL_W-1:0] col;
    } dec_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ROW_ACTIVE,
        ST_READ,
        ST_READ_AP,
        ST_WRITE,
        ST_WRITE_REC,
        ST_PRECHARGE,
        ST_REFRESH,
        ST_SELF_REFRESH,
        ST_POWER_DOWN,
        ST_FREEZE
    } dev_state_t;

endpackage

// file: rtl/sdram_cmd_decode.sv
// decode of the command pins into a command and its fields
`timescale 1ns/100ps
`include "sdram_cmd_cfg.svh"
module sdram_cmd_decode
    import sdram_cmd_pkg::*;
(
    // pins
    input cmd_pins_t pins,
    // decoded
    output dec_t dec
);

    always_comb begin
        dec.autoclose = pins.addr[`AUTOCLOSE_BIT];
        dec.bank = pins.addr[`BANK_BIT];
        dec.col = pins.addr[`COL_W-1:0];
        dec.cmd = CMD_DESELECT;
        if (!pins.cs_n) begin
            unique case ({pins.ras_n, pins.cas_n, pins.we_n})
                `CODE_IDLE_CYCLE: dec.cmd = CMD_IDLE_CYCLE;
                `CODE_BURST_HALT: dec.cmd = CMD_BURST_HALT;
                `CODE_FETCH: dec.cmd = CMD_FETCH;
                `CODE_STORE: dec.cmd = CMD_STORE;
                `CODE_ROW_OPEN: dec.cmd = CMD_ROW_OPEN;
                `CODE_BANK_CLOSE: dec.cmd = CMD_BANK_CLOSE;
                `CODE_RENEW: dec.cmd = CMD_RENEW;
                `CODE_CONFIG_LOAD: dec.cmd = CMD_CONFIG_LOAD;
            endcase
        end
    end

endmodule

// file: rtl/sdram_rd_fifo.sv
// small fifo between the read burst and the data consumer
`timescale 1ns/100ps
module sdram_rd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    // depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != FULL_COUNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            if (push && !pop) begin
                count_r <= count_r + (AW + 1)'(1);
            end else if (pop && !push) begin
                count_r <= count_r - (AW + 1)'(1);
            end
        end
    end

endmodule

// file: tb/mem_ctrl_model.sv
// controller model that issues commands to the sdram state machine
`timescale 1ns/100ps
`include "sdram_cmd_cfg.svh"
module mem_ctrl_model
    import sdram_cmd_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // command pins
    output cmd_pins_t pins
);
    initial begin
        pins = {4'hf, 1'b1, 12'h000};
    end

    // one command per edge; it stands until rest or the next command replaces it
    task automatic cmd(input logic [2:0] code, input logic [11:0] a, input logic gate);
        pins.cs_n = 1'b0;
        {pins.ras_n, pins.cas_n, pins.we_n} = code;
        pins.addr = a;
        pins.clock_gate_input = gate;
        @(posedge sys_clk);
        #1;
    endtask

    // deselect while waiting, so a read with auto close only sees idle cycles
    task automatic rest();
        pins.cs_n = 1'b1;
    endtask
endmodule

// file: tb/sdram_command_state_machine_tb_top.sv
// self-checking bench for the sdram command state machine
`timescale 1ns/100ps
`include "sdram_cmd_cfg.svh"
module sdram_command_state_machine_tb_top
    import sdram_cmd_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`DATA_W-1:0] wr_data = '0;
    logic rd_ready = 1'b1;
    cmd_pins_t pins;
    logic rd_valid;
    logic [`DATA_W-1:0] rd_data;
    dev_state_t dev_state;
    logic [`NUM_BANKS-1:0] bank_open;
    logic illegal_cmd;
    int n_errors = 0;
    int cmp_count = 0;

    always #20 sys_clk = ~sys_clk;

    mem_ctrl_model u_ctrl (.sys_clk(sys_clk), .pins(pins));
    sdram_cmd_fsm u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .dev_state(dev_state),
        .bank_open(bank_open), .illegal_cmd(illegal_cmd));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic st(input dev_state_t exp);
        chk("dev_state", 16'(exp), 16'(dev_state));
    endtask

    task automatic idle(input int n);
        u_ctrl.rest();
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // a short state may be missed by a single look, so watch a window
    task automatic saw(input dev_state_t exp);
        logic hit;
        hit = 1'b0;
        repeat (8) begin
            hit |= (dev_state === exp);
            idle(1);
        end
        chk(exp.name(), 16'h1, 16'(hit));
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] b);
        u_ctrl.cmd(`CODE_STORE, a, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr_data = b + 16'(i);
            idle(1);
        end
    endtask

    // consumer stalls first; the fifo and the output register must hold the whole burst meanwhile
    task automatic rd(input logic [11:0] a, input logic [15:0] b, input dev_state_t fin);
        int k;
        k = 0;
        u_ctrl.cmd(`CODE_FETCH, a, 1'b1);
        rd_ready = 1'b0;
        idle(6);
        rd_ready = 1'b1;
        repeat (12) begin
            if (rd_valid === 1'b1 && k < 4) begin
                chk("rd_data", b + 16'(k), rd_data);
                k++;
            end
            idle(1);
        end
        chk("words", 16'h4, 16'(k));
        st(fin);
    endtask

    task automatic t_idle();
        st(ST_IDLE);
        chk("bank_open", 16'h0, 16'(bank_open));
        u_ctrl.cmd(`CODE_BURST_HALT, 12'h000, 1'b1);
        st(ST_IDLE);
        u_ctrl.cmd(`CODE_FETCH, 12'h010, 1'b1);
        chk("illegal_cmd", 16'h1, 16'(illegal_cmd));
        u_ctrl.cmd(`CODE_CONFIG_LOAD, 12'h000, 1'b1);
        chk("illegal_cmd", 16'h0, 16'(illegal_cmd));
        u_ctrl.cmd(`CODE_BANK_CLOSE, 12'h400, 1'b1);
        st(ST_IDLE);
        u_ctrl.cmd(`CODE_IDLE_CYCLE, 12'h000, 1'b0);
        idle(3);
        st(ST_POWER_DOWN);
        u_ctrl.cmd(`CODE_IDLE_CYCLE, 12'h000, 1'b1);
        st(ST_IDLE);
        // the run is far shorter than the renew period, so one renew keeps the pace
        u_ctrl.cmd(`CODE_RENEW, 12'h000, 1'b1);
        st(ST_REFRESH);
        idle(2);
        st(ST_IDLE);
        idle(1);
        u_ctrl.cmd(`CODE_RENEW, 12'h000, 1'b0);
        idle(3);
        st(ST_SELF_REFRESH);
        u_ctrl.cmd(`CODE_IDLE_CYCLE, 12'h000, 1'b1);
        st(ST_REFRESH);
        idle(2);
        st(ST_IDLE);
    endtask

    task automatic t_rw();
        u_ctrl.cmd(`CODE_ROW_OPEN, 12'h000, 1'b1);
        st(ST_ROW_ACTIVE);
        chk("bank_open", 16'h1, 16'(bank_open));
        u_ctrl.cmd(`CODE_ROW_OPEN, 12'h800, 1'b1);
        chk("illegal_cmd", 16'h1, 16'(illegal_cmd));
        wr(12'h010, 16'ha5c0);
        saw(ST_WRITE_REC);
        st(ST_ROW_ACTIVE);
        rd(12'h010, 16'ha5c0, ST_ROW_ACTIVE);
        u_ctrl.cmd(`CODE_FETCH, 12'h010, 1'b1);
        u_ctrl.cmd(`CODE_BURST_HALT, 12'h000, 1'b1);
        st(ST_ROW_ACTIVE);
        u_ctrl.cmd(`CODE_FETCH, 12'h010, 1'b1);
        u_ctrl.cmd(`CODE_STORE, 12'h010, 1'b1);
        st(ST_WRITE);
        u_ctrl.cmd(`CODE_STORE, 12'h020, 1'b1);
        st(ST_WRITE);
        u_ctrl.cmd(`CODE_BURST_HALT, 12'h000, 1'b1);
        st(ST_ROW_ACTIVE);
        u_ctrl.cmd(`CODE_STORE, 12'h010, 1'b1);
        u_ctrl.cmd(`CODE_FETCH, 12'h010, 1'b1);
        st(ST_READ);
        u_ctrl.cmd(`CODE_FETCH, 12'h020, 1'b1);
        st(ST_READ);
        u_ctrl.cmd(`CODE_BANK_CLOSE, 12'h000, 1'b1);
        saw(ST_PRECHARGE);
        st(ST_IDLE);
    endtask

    task automatic t_freeze();
        u_ctrl.cmd(`CODE_ROW_OPEN, 12'h000, 1'b1);
        u_ctrl.cmd(`CODE_BANK_CLOSE, 12'h000, 1'b0);
        st(ST_FREEZE);
        idle(2);
        u_ctrl.cmd(`CODE_BANK_CLOSE, 12'h000, 1'b1);
        st(ST_ROW_ACTIVE);
        idle(1);
        rd(12'h410, 16'ha5c0, ST_IDLE);
        chk("bank_open", 16'h0, 16'(bank_open));
        // a stray write during a read with auto close is flagged and changes nothing
        u_ctrl.cmd(`CODE_ROW_OPEN, 12'h000, 1'b1);
        u_ctrl.cmd(`CODE_FETCH, 12'h410, 1'b1);
        u_ctrl.cmd(`CODE_STORE, 12'h010, 1'b1);
        chk("illegal_cmd", 16'h1, 16'(illegal_cmd));
        st(ST_READ_AP);
        idle(8);
        st(ST_IDLE);
        u_ctrl.cmd(`CODE_ROW_OPEN, 12'h000, 1'b1);
        u_ctrl.cmd(`CODE_STORE, 12'h010, 1'b1);
        u_ctrl.cmd(`CODE_BANK_CLOSE, 12'h400, 1'b1);
        st(ST_PRECHARGE);
        chk("bank_open", 16'h0, 16'(bank_open));
        idle(1);
        st(ST_IDLE);
    endtask

    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_idle();
        t_rw();
        t_freeze();
        end_of_test();
    end
endmodule
